// ### src/lmr_regs.svh
`ifndef LMR_REGS_SVH
`define LMR_REGS_SVH
// What this block does
// - Loop voltage bit 6 flags negative polarity.
// - Loop voltage bits 5:0 magnitude, 1.5 V/code.
// - Loop current bit 6 flags reverse flow.
// - Loop current bits 5:0 magnitude, 1.25 mA/code.
// - TIP voltage: unsigned 8-bit, .376 V steps.
// - RING voltage: unsigned 8-bit, same scale.
// - Two battery voltage registers, same scale.
// - First transistor current, 8-bit, .319 mA steps.
// - Second transistor current, same scale.
// - Extended bias on: exclude added bias current.

// Register indices; the byte address is four times the index.
`define LMR_IDX_LOOP_VOLTAGE 10'h04E
`define LMR_IDX_LOOP_CURRENT 10'h04F
`define LMR_IDX_TIP_VOLTAGE 10'h050
`define LMR_IDX_RING_VOLTAGE 10'h051
`define LMR_IDX_BATTERY_A 10'h052
`define LMR_IDX_BATTERY_B 10'h053
`define LMR_IDX_FIRST_TRANSISTOR 10'h054
`define LMR_IDX_SECOND_TRANSISTOR 10'h055
`define LMR_IDX_BIAS_CONTROL 10'h060
`define LMR_IDX_SAMPLE_COUNT 10'h061

// Field positions.
`define LMR_SIGN_BIT 6
`define LMR_MAG_MSB 5
`define LMR_BIAS_ENABLE_BIT 0
`define LMR_BIAS_SETTING_LSB 8
`define LMR_BIAS_SETTING_MSB 15

// Reset values.
`define LMR_RESET_MEAS 8'h00
`define LMR_RESET_BIAS_SETTING 8'h00
`define LMR_RESET_COUNT 16'h0000

// Largest magnitude code of a loop register.
`define LMR_MAG_MAX 6'h3F

`endif

// ### src/lmr_pkg.sv
package lmr_pkg;

  typedef logic [7:0] lmr_byte_t;

  typedef enum logic [1:0] {
    LMR_RESP_OKAY = 2'h0,
    LMR_RESP_SLVERR = 2'h2
  } lmr_resp_t;

endpackage : lmr_pkg

// ### src/lmr_bias_comp.sv
`include "lmr_regs.svh"

module lmr_bias_comp (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw sample and its strobe
  input wire logic load,
  input wire lmr_pkg::lmr_byte_t raw_current,
  // Extended bias state
  input wire logic bias_enable,
  input wire lmr_pkg::lmr_byte_t bias_current,
  // Reported value
  output lmr_pkg::lmr_byte_t reported_ff
);

  // Subtracting below zero would wrap to a large current, so the result floors at zero.
  logic [8:0] diff;
  lmr_pkg::lmr_byte_t nxt_reported;

  assign diff = {1'b0, raw_current} - {1'b0, bias_current};
  assign nxt_reported = !bias_enable ? raw_current :
                        (diff[8] ? `LMR_RESET_MEAS : diff[7:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reported_ff <= `LMR_RESET_MEAS;
    end else if (load) begin
      reported_ff <= nxt_reported;
    end
  end

endmodule : lmr_bias_comp

// ### src/lmr_readout.sv
// Chosen here: the AXI4-Lite interface to the registers.
`include "lmr_regs.svh"

module lmr_readout #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Converter samples, all valid when sample_valid is high
  input wire logic sample_valid,
  input wire logic [7:0] loop_voltage_raw,
  input wire logic [7:0] loop_current_raw,
  input wire lmr_pkg::lmr_byte_t tip_voltage_raw,
  input wire lmr_pkg::lmr_byte_t ring_voltage_raw,
  input wire lmr_pkg::lmr_byte_t battery_voltage_raw_a,
  input wire lmr_pkg::lmr_byte_t battery_voltage_raw_b,
  input wire lmr_pkg::lmr_byte_t first_transistor_raw,
  input wire lmr_pkg::lmr_byte_t second_transistor_raw,
  // Extended bias controls towards the line driver
  output logic extended_bias_enable,
  output lmr_pkg::lmr_byte_t extended_bias_current_setting
);

  // Signed code to sign flag plus saturated six-bit magnitude.
  function automatic logic [6:0] sign_mag(input logic [7:0] v);
    logic [7:0] mag;
    mag = v[7] ? 8'(~v + 8'h01) : v;
    if (mag > 8'({2'h0, `LMR_MAG_MAX})) begin
      mag = 8'({2'h0, `LMR_MAG_MAX});
    end
    return {v[7], mag[5:0]};
  endfunction : sign_mag

  // Byte address to register index.
  function automatic logic [9:0] idx_of(input logic [ADDR_W-1:0] a);
    return 10'(a >> 2);
  endfunction : idx_of

  // Measurement registers.
  logic [6:0] loop_voltage_ff;
  logic [6:0] loop_current_ff;
  lmr_pkg::lmr_byte_t tip_voltage_value_ff;
  lmr_pkg::lmr_byte_t ring_voltage_value_ff;
  lmr_pkg::lmr_byte_t battery_voltage_value_a_ff;
  lmr_pkg::lmr_byte_t battery_voltage_value_b_ff;
  lmr_pkg::lmr_byte_t first_transistor_current_value;
  lmr_pkg::lmr_byte_t second_transistor_current_value;
  logic [15:0] sample_count_ff;

  // Control registers.
  logic bias_enable_ff;
  lmr_pkg::lmr_byte_t bias_setting_ff;

  // Bus state.
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Loop quantities arrive as two's complement and are split into sign and magnitude.
  logic [6:0] nxt_loop_voltage;
  logic [6:0] nxt_loop_current;
  assign nxt_loop_voltage = sign_mag(loop_voltage_raw);
  assign nxt_loop_current = sign_mag(loop_current_raw);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_voltage_ff <= 7'h00;
      loop_current_ff <= 7'h00;
      tip_voltage_value_ff <= `LMR_RESET_MEAS;
      ring_voltage_value_ff <= `LMR_RESET_MEAS;
      battery_voltage_value_a_ff <= `LMR_RESET_MEAS;
      battery_voltage_value_b_ff <= `LMR_RESET_MEAS;
    end else if (sample_valid) begin
      loop_voltage_ff <= nxt_loop_voltage;
      loop_current_ff <= nxt_loop_current;
      tip_voltage_value_ff <= tip_voltage_raw;
      ring_voltage_value_ff <= ring_voltage_raw;
      battery_voltage_value_a_ff <= battery_voltage_raw_a;
      battery_voltage_value_b_ff <= battery_voltage_raw_b;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_count_ff <= `LMR_RESET_COUNT;
    end else if (sample_valid) begin
      sample_count_ff <= sample_count_ff + 16'h0001;
    end
  end

  // Transistor currents pass through bias compensation before they are reported.
  lmr_bias_comp u_first_comp (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(sample_valid),
    .raw_current(first_transistor_raw),
    .bias_enable(bias_enable_ff),
    .bias_current(bias_setting_ff),
    .reported_ff(first_transistor_current_value)
  );

  lmr_bias_comp u_second_comp (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(sample_valid),
    .raw_current(second_transistor_raw),
    .bias_enable(bias_enable_ff),
    .bias_current(bias_setting_ff),
    .reported_ff(second_transistor_current_value)
  );

  // Write path: address and data are taken in either order and held until both are present.
  logic aw_take;
  logic w_take;
  logic aw_have;
  logic w_have;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [9:0] wr_idx;
  logic wr_is_ctrl;
  logic wr_is_meas;
  logic wr_mapped;

  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign aw_have = aw_held_ff || aw_take;
  assign w_have = w_held_ff || w_take;
  assign do_write = aw_have && w_have && !bvalid_ff;
  assign wr_addr = aw_held_ff ? awaddr_ff : awaddr;
  assign wr_data = w_held_ff ? wdata_ff : wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : wstrb;
  assign wr_idx = idx_of(wr_addr);
  assign wr_is_ctrl = wr_idx == `LMR_IDX_BIAS_CONTROL;
  assign wr_is_meas = (wr_idx >= `LMR_IDX_LOOP_VOLTAGE) && (wr_idx <= `LMR_IDX_SECOND_TRANSISTOR);
  assign wr_mapped = wr_is_ctrl || wr_is_meas || (wr_idx == `LMR_IDX_SAMPLE_COUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else if (aw_take) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else if (w_take) begin
      w_held_ff <= 1'b1;
      wdata_ff <= wdata;
      wstrb_ff <= wstrb;
    end
  end

  // Only the control word stores; writes to measurement registers change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_enable_ff <= 1'b0;
      bias_setting_ff <= `LMR_RESET_BIAS_SETTING;
    end else if (do_write && wr_is_ctrl) begin
      if (wr_strb[0]) begin
        bias_enable_ff <= wr_data[`LMR_BIAS_ENABLE_BIT];
      end
      if (wr_strb[1]) begin
        bias_setting_ff <= wr_data[`LMR_BIAS_SETTING_MSB:`LMR_BIAS_SETTING_LSB];
      end
    end
  end

  // Read-only registers answer OKAY and ignore the data; unmapped addresses get SLVERR.
  lmr_pkg::lmr_resp_t wr_resp;
  assign wr_resp = wr_mapped ? lmr_pkg::LMR_RESP_OKAY : lmr_pkg::LMR_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_resp;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // Read path: one outstanding read, answered one cycle after the address is taken.
  logic ar_take;
  logic [9:0] rd_idx;
  logic rd_mapped;
  lmr_pkg::lmr_byte_t rd_byte;
  logic [31:0] rd_word;
  logic [31:0] ctrl_word;

  assign arready = !rvalid_ff;
  assign ar_take = arvalid && arready;
  assign rd_idx = idx_of(araddr);
  assign ctrl_word = {16'h0000, bias_setting_ff, 7'h00, bias_enable_ff};

  assign rd_byte =
    (rd_idx == `LMR_IDX_LOOP_VOLTAGE) ? {1'b0, loop_voltage_ff} :
    (rd_idx == `LMR_IDX_LOOP_CURRENT) ? {1'b0, loop_current_ff} :
    (rd_idx == `LMR_IDX_TIP_VOLTAGE) ? tip_voltage_value_ff :
    (rd_idx == `LMR_IDX_RING_VOLTAGE) ? ring_voltage_value_ff :
    (rd_idx == `LMR_IDX_BATTERY_A) ? battery_voltage_value_a_ff :
    (rd_idx == `LMR_IDX_BATTERY_B) ? battery_voltage_value_b_ff :
    (rd_idx == `LMR_IDX_FIRST_TRANSISTOR) ? first_transistor_current_value :
    (rd_idx == `LMR_IDX_SECOND_TRANSISTOR) ? second_transistor_current_value :
    `LMR_RESET_MEAS;

  assign rd_mapped = ((rd_idx >= `LMR_IDX_LOOP_VOLTAGE) && (rd_idx <= `LMR_IDX_SECOND_TRANSISTOR))
                     || (rd_idx == `LMR_IDX_BIAS_CONTROL) || (rd_idx == `LMR_IDX_SAMPLE_COUNT);
  assign rd_word = (rd_idx == `LMR_IDX_BIAS_CONTROL) ? ctrl_word :
                   (rd_idx == `LMR_IDX_SAMPLE_COUNT) ? {16'h0000, sample_count_ff} :
                   {24'h00_0000, rd_byte};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mapped ? rd_word : 32'h0000_0000;
      rresp_ff <= rd_mapped ? lmr_pkg::LMR_RESP_OKAY : lmr_pkg::LMR_RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // Drive the bias controls straight from their register bits.
  assign extended_bias_enable = bias_enable_ff;
  assign extended_bias_current_setting = bias_setting_ff;

endmodule : lmr_readout

// ### tb/lmr_chk.sv
`include "lmr_regs.svh"

module lmr_chk #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // Read side
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Samples and bias
  input wire logic sample_valid,
  input wire logic [7:0] loop_voltage_raw,
  input wire logic [7:0] loop_current_raw,
  input wire logic extended_bias_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [ADDR_W-3:0] idx_ff;
  logic [7:0] lv_ff;
  logic [7:0] lc_ff;
  // The read index is kept so that read data is judged against its own register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_ff <= '0;
      lv_ff <= '0;
      lc_ff <= '0;
    end else begin
      if (arvalid && arready) begin
        idx_ff <= araddr[ADDR_W-1:2];
      end
      if (sample_valid) begin
        lv_ff <= loop_voltage_raw;
        lc_ff <= loop_current_raw;
      end
    end
  end
  wire is_lv = idx_ff == `LMR_IDX_LOOP_VOLTAGE;
  wire is_lc = idx_ff == `LMR_IDX_LOOP_CURRENT;
  wire in_meas = idx_ff >= `LMR_IDX_LOOP_VOLTAGE && idx_ff <= `LMR_IDX_SECOND_TRANSISTOR;
  wire mapped = in_meas || idx_ff == `LMR_IDX_BIAS_CONTROL || idx_ff == `LMR_IDX_SAMPLE_COUNT;
  sequence s_ar;
    arvalid && arready;
  endsequence
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  a_read_latency: assert property (s_ar |=> rvalid) else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_ar_blocked: assert property (rvalid |-> !arready) else $error("read taken while busy");
  a_write_latency: assert property (s_wr |=> bvalid) else $error("write answer late");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
  a_loop_top_zero: assert property (
    $rose(rvalid) && (is_lv || is_lc) |-> rdata[31:7] == '0) else $error("loop bit 7 set");
  a_volt_sign: assert property (
    $rose(rvalid) && is_lv |-> rdata[6] == lv_ff[7]) else $error("voltage sign wrong");
  a_curr_sign: assert property (
    $rose(rvalid) && is_lc |-> rdata[6] == lc_ff[7]) else $error("current sign wrong");
  a_unmapped_err: assert property ($rose(rvalid) && !mapped |-> rresp == 2'h2 && rdata == '0)
    else $error("unmapped read not refused");
  // Only a completed write may move the bias control towards the line driver.
  a_bias_by_write: assert property ($changed(extended_bias_enable) |-> $rose(bvalid))
    else $error("bias changed without write");
endmodule : lmr_chk

bind lmr_readout lmr_chk #(.ADDR_W(ADDR_W)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sample_valid(sample_valid),
  .loop_voltage_raw(loop_voltage_raw), .loop_current_raw(loop_current_raw),
  .extended_bias_enable(extended_bias_enable));

// ### tb/line_measurement_readout_tb.sv
module line_measurement_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, sample_valid = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, bias_en;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, data;
  logic [7:0] raw [8] = '{default: 8'h00};
  lmr_pkg::lmr_byte_t bias_set;
  logic [7:0] lin [6] = '{8'h05, 8'hFB, 8'h80, 8'h3F, 8'hC1, 8'h40};
  logic [7:0] lexp [6] = '{8'h05, 8'h45, 8'h7F, 8'h3F, 8'h7F, 8'h3F};
  int miscompares = 0, checks = 0, cycles = 0;
  lmr_readout dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sample_valid(sample_valid), .loop_voltage_raw(raw[0]),
    .loop_current_raw(raw[1]), .tip_voltage_raw(raw[2]), .ring_voltage_raw(raw[3]),
    .battery_voltage_raw_a(raw[4]), .battery_voltage_raw_b(raw[5]),
    .first_transistor_raw(raw[6]), .second_transistor_raw(raw[7]),
    .extended_bias_enable(bias_en), .extended_bias_current_setting(bias_set));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Outputs are read just after the edge, before that edge's own updates land.
  // A late master keeps its ready low until the answer shows, so held answers get exercised.
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input bit late = 1'b0);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late;
    do begin
      @(posedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      resp = bresp;
      if (ha) begin
        awvalid <= 1'b0;
      end
      if (hw) begin
        wvalid <= 1'b0;
      end
      if (bvalid && !bready) begin
        bready <= 1'b1;
      end
    end while (!hb);
    bready <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er,
                       input bit late = 1'b0);
    logic ha, hr;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= !late;
    do begin
      @(posedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      data = rdata;
      resp = rresp;
      if (ha) begin
        arvalid <= 1'b0;
      end
      if (rvalid && !rready) begin
        rready <= 1'b1;
      end
    end while (!hr);
    rready <= 1'b0;
    chk(data, e);
    chk({30'h0, resp}, {30'h0, er});
  endtask : rdchk
  task automatic smp(input logic [63:0] v);
    @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      raw[i] <= v[8*i+:8];
    end
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
  endtask : smp
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rdchk(10'h04E + 10'(i), 32'h0, 2'h0);
    end
    rdchk(10'h060, 32'h0, 2'h0);
    rdchk(10'h061, 32'h0, 2'h0);
  endtask : t_reset
  task automatic t_loop;
    for (int i = 0; i < 6; i++) begin
      smp({48'h0, lin[i], lin[i]});
      rdchk(10'h04E, {24'h0, lexp[i]}, 2'h0);
      rdchk(10'h04F, {24'h0, lexp[i]}, 2'h0);
    end
  endtask : t_loop
  task automatic t_plain;
    logic [63:0] v = 64'h7F80_01FF_5AA5_0000;
    smp(v);
    for (int i = 2; i < 8; i++) begin
      rdchk(10'h04E + 10'(i), {24'h0, v[8*i+:8]}, 2'h0);
    end
  endtask : t_plain
  task automatic t_bias;
    wr(10'h060, 32'h0000_2001);
    chk({31'h0, bias_en}, 32'h1);
    chk({24'h0, bias_set}, 32'h20);
    rdchk(10'h060, 32'h0000_2001, 2'h0);
    smp(64'h1050_0000_0000_0000);
    rdchk(10'h054, 32'h30, 2'h0);
    rdchk(10'h055, 32'h00, 2'h0);
    wr(10'h060, 32'h0, 1'b1);
    chk({31'h0, bias_en}, 32'h0);
    smp(64'h1050_0000_0000_0000);
    rdchk(10'h054, 32'h50, 2'h0);
    rdchk(10'h055, 32'h10, 2'h0, 1'b1);
  endtask : t_bias
  task automatic t_ro;
    logic [63:0] v = 64'h1050_0000_0000_0000;
    for (int i = 0; i < 8; i++) begin
      wr(10'h04E + 10'(i), 32'hFF);
      chk({30'h0, resp}, 32'h0);
      rdchk(10'h04E + 10'(i), {24'h0, v[8*i+:8]}, 2'h0);
    end
    wr(10'h061, 32'hFF);
    chk({30'h0, resp}, 32'h0);
    rdchk(10'h061, 32'h9, 2'h0);
    rdchk(10'h3FF, 32'h0, 2'h2);
    wr(10'h3FF, 32'h1);
    chk({30'h0, resp}, 32'h2);
  endtask : t_ro
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_loop();
    t_plain();
    t_bias();
    t_ro();
    stop_test();
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end
endmodule : line_measurement_readout_tb
